// ===== src/timer_pkg.sv
/*
 * Shared constants and types for the 8-bit waveform timer: register map,
 * field positions, reset values, mode encodings and prescaler ratios.
 * Assumes a 32-bit AXI4-Lite register bus with one register per word.
 */
package timer_pkg;

   localparam int unsigned CLK_HZ = 50_000_000;

   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_COUNT   = 8'h04;
   localparam logic [7:0] ADDR_CMP_A   = 8'h08;
   localparam logic [7:0] ADDR_CMP_B   = 8'h0c;
   localparam logic [7:0] ADDR_FLAGS   = 8'h10;

   // Control register fields
   localparam int CTRL_WGM_LSB  = 0;
   localparam int CTRL_CS_LSB   = 4;
   localparam int CTRL_COMB_LSB = 8;
   localparam int CTRL_COMA_LSB = 10;
   localparam logic [11:0] CTRL_RESET = 12'h000;

   // Flag register fields
   localparam int FLAG_OVF  = 0;
   localparam int FLAG_MATA = 1;
   localparam int FLAG_MATB = 2;

   localparam logic [7:0] COUNT_BOTTOM = 8'h00;
   localparam logic [7:0] COUNT_MAX    = 8'hff;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [2:0] {
      WGM_NORMAL   = 3'b000,
      WGM_PC_FF    = 3'b001,
      WGM_CTC      = 3'b010,
      WGM_FAST_FF  = 3'b011,
      WGM_RSV4     = 3'b100,
      WGM_PC_OCR   = 3'b101,
      WGM_RSV6     = 3'b110,
      WGM_FAST_OCR = 3'b111
   } waveform_mode_type;

   typedef enum logic [1:0] {
      COM_OFF    = 2'b00,
      COM_TOGGLE = 2'b01,
      COM_CLEAR  = 2'b10,
      COM_SET    = 2'b11
   } compare_out_mode_type;

   // Prescaler terminal counts (ratio minus one)
   localparam logic [9:0] DIV_8    = 10'h007;
   localparam logic [9:0] DIV_64   = 10'h03f;
   localparam logic [9:0] DIV_256  = 10'h0ff;
   localparam logic [9:0] DIV_1024 = 10'h3ff;

   typedef struct packed {
      compare_out_mode_type compare_out_mode_a;
      compare_out_mode_type compare_out_mode_b;
      logic                 reserved;
      logic [2:0]           clock_source_sel;
      logic                 pad;
      logic [2:0]           waveform_mode_sel;
   } ctrl_type;

   typedef struct packed {
      logic match_b;
      logic match_a;
      logic overflow;
   } flags_type;

endpackage : timer_pkg

// ===== src/timer_prescaler.sv
/*
 * Prescaler: divides the system clock into a one-cycle timer tick.
 * Assumes the selection changes rarely; the divider keeps its count on a change and clears only at selection zero or its limit.
 */
`timescale 1ns/1ps
module timer_prescaler
   import timer_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [2:0] clock_source_sel,
   output logic            tick
);

   logic [9:0] div_r;
   logic [9:0] limit;

   always_comb begin
      case (clock_source_sel)
         3'h2:    limit = DIV_8;
         3'h3:    limit = DIV_64;
         3'h4:    limit = DIV_256;
         3'h5:    limit = DIV_1024;
         default: limit = 10'h000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || clock_source_sel == 3'h0 || div_r >= limit) begin
         div_r <= 10'h000;
      end else begin
         div_r <= div_r + 10'h001;
      end
   end

   // Selection zero stops the timer; codes 6 and 7 also stop it
   assign tick = (clock_source_sel != 3'h0) && (clock_source_sel < 3'h6)
                 && (div_r >= limit);

endmodule : timer_prescaler

// ===== src/timer_wave_out.sv
/*
 * One waveform output channel: applies compare output mode to the
 * match, bottom and direction events of the counter.
 * Assumes events arrive already qualified by the timer tick.
 */
`timescale 1ns/1ps
module timer_wave_out
   import timer_pkg::*;
#(
   parameter bit TOGGLE_IN_PWM = 1'b1
)
(
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic [2:0]           waveform_mode_sel,
   input  compare_out_mode_type      mode,
   input  wire logic                 match,
   input  wire logic                 at_bottom,
   input  wire logic                 at_top,
   input  wire logic                 cmp_is_top,
   input  wire logic                 counting_up,
   output logic                      wave_out
);

   logic wave_r;
   logic fast;
   logic phase;

   assign fast  = waveform_mode_sel == WGM_FAST_FF
               || waveform_mode_sel == WGM_FAST_OCR;
   assign phase = waveform_mode_sel == WGM_PC_FF
               || waveform_mode_sel == WGM_PC_OCR;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wave_r <= 1'b0;
      end else if (fast) begin
         if (mode == COM_TOGGLE) begin
            if (TOGGLE_IN_PWM && waveform_mode_sel[2] && match)
               wave_r <= ~wave_r;
         end else if (mode[1]) begin
            // Match with compare at COUNT_MAX ignored so compare at max stays constant
            if (at_bottom)
               wave_r <= ~mode[0];
            else if (match && !cmp_is_top)
               wave_r <= mode[0];
         end
      end else if (phase) begin
         if (mode == COM_TOGGLE) begin
            if (TOGGLE_IN_PWM && waveform_mode_sel[2] && match)
               wave_r <= ~wave_r;
         end else if (mode[1]) begin
            if (match && cmp_is_top && at_top)
               wave_r <= ~mode[0];
            else if (match && !cmp_is_top)
               wave_r <= counting_up ? mode[0] : ~mode[0];
         end
      end else if (match) begin
         case (mode)
            COM_TOGGLE: wave_r <= ~wave_r;
            COM_CLEAR:  wave_r <= 1'b0;
            COM_SET:    wave_r <= 1'b1;
            default:    wave_r <= wave_r;
         endcase
      end
   end

   assign wave_out = wave_r;

endmodule : timer_wave_out

// ===== src/timer_waveform_modes.sv
/*
 * 8-bit timer/counter with normal, clear-on-match, fast PWM and
 * phase-correct PWM waveform modes, reached over AXI4-Lite.
 * Assumes one clock, synchronous active-low reset, and a master that
 * keeps at most one write and one read outstanding.
 */
`timescale 1ns/1ps
module timer_waveform_modes
   import timer_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             wave_out_a,
   output logic             wave_out_b
);

   ctrl_type   ctrl_r;
   flags_type  flags_r;
   logic [7:0] count_value_r;
   logic [7:0] count_value_nxt;
   logic [7:0] cmp_a_buf_r;
   logic [7:0] cmp_b_buf_r;
   logic [7:0] compare_level_a_r;
   logic [7:0] compare_level_b_r;
   logic       down_r;
   logic       block_r;
   logic       match_a_pend_r;
   logic       match_b_pend_r;
   logic       ovf_pend_r;

   logic [7:0]  aw_addr_r;
   logic        aw_have_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        w_have_r;
   logic        wr_fire;
   logic        rd_fire;

   logic       tick;
   waveform_mode_type mode;
   logic       fast;
   logic       phase;
   logic       buffered;
   logic [7:0] top;
   logic       at_top;
   logic       at_bottom_evt;
   logic       match_a;
   logic       match_b;
   logic       cnt_write;
   logic       flag_write;
   logic       ovf_evt;

   timer_prescaler u_prescaler (
      .aclk             (aclk),
      .aresetn          (aresetn),
      .clock_source_sel (ctrl_r.clock_source_sel),
      .tick             (tick)
   );

   // Modes 4 and 6 fall through to the normal-mode sequence
   always_comb begin
      mode = waveform_mode_type'(ctrl_r.waveform_mode_sel);
      if (mode == WGM_RSV4 || mode == WGM_RSV6)
         mode = WGM_NORMAL;
   end

   assign fast     = mode == WGM_FAST_FF || mode == WGM_FAST_OCR;
   assign phase    = mode == WGM_PC_FF || mode == WGM_PC_OCR;
   assign buffered = fast || phase;
   assign top      = (mode == WGM_FAST_OCR || mode == WGM_PC_OCR
                      || mode == WGM_CTC) ? compare_level_a_r
                                          : COUNT_MAX;
   assign at_top   = count_value_r == top;

   // AXI4-Lite write side: address and data taken in either order
   assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
   assign wr_fire       = aw_have_r && w_have_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_have_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_r <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_have_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (aw_addr_r[7:2] > ADDR_FLAGS[7:2])
                         ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign cnt_write  = wr_fire && aw_addr_r[7:2] == ADDR_COUNT[7:2]
                       && w_strb_r[0];
   assign flag_write = wr_fire && aw_addr_r[7:2] == ADDR_FLAGS[7:2]
                       && w_strb_r[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= ctrl_type'(CTRL_RESET);
      end else if (wr_fire && aw_addr_r[7:2] == ADDR_CTRL[7:2]) begin
         if (w_strb_r[0])
            ctrl_r[7:0] <= w_data_r[7:0];
         if (w_strb_r[1])
            ctrl_r[11:8] <= w_data_r[11:8];
      end
   end

   // Software always reads the buffer; outside PWM modes the live level copies it every cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_a_buf_r <= 8'h00;
         cmp_b_buf_r <= 8'h00;
      end else if (wr_fire && w_strb_r[0]) begin
         if (aw_addr_r[7:2] == ADDR_CMP_A[7:2])
            cmp_a_buf_r <= w_data_r[7:0];
         else if (aw_addr_r[7:2] == ADDR_CMP_B[7:2])
            cmp_b_buf_r <= w_data_r[7:0];
      end
   end

   // Fast PWM loads at bottom, phase-correct at top
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         compare_level_a_r <= 8'h00;
         compare_level_b_r <= 8'h00;
      end else if (!buffered) begin
         compare_level_a_r <= cmp_a_buf_r;
         compare_level_b_r <= cmp_b_buf_r;
      end else if (tick && ((fast && at_top) || (phase && at_top))) begin
         compare_level_a_r <= cmp_a_buf_r;
         compare_level_b_r <= cmp_b_buf_r;
      end
   end

   // Counting sequence
   always_comb begin
      count_value_nxt = count_value_r;
      if (phase) begin
         if (down_r)
            count_value_nxt = count_value_r - 8'h01;
         else if (!at_top)
            count_value_nxt = count_value_r + 8'h01;
         else
            count_value_nxt = count_value_r - 8'h01;
      end else if ((mode == WGM_CTC || fast) && at_top) begin
         count_value_nxt = COUNT_BOTTOM;
      end else begin
         count_value_nxt = count_value_r + 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_value_r <= COUNT_BOTTOM;
      end else if (cnt_write) begin
         count_value_r <= w_data_r[7:0];
      end else if (tick) begin
         count_value_r <= count_value_nxt;
      end
   end

   // Direction turns at top and bottom of the dual slope
   always_ff @(posedge aclk) begin
      if (!aresetn || !phase) begin
         down_r <= 1'b0;
      end else if (tick) begin
         if (at_top && !down_r)
            down_r <= 1'b1;
         else if (count_value_r == 8'h01 && down_r)
            down_r <= 1'b0;
      end
   end

   // Count write blocks matches in the following tick
   always_ff @(posedge aclk) begin
      if (!aresetn)
         block_r <= 1'b0;
      else if (cnt_write)
         block_r <= 1'b1;
      else if (tick)
         block_r <= 1'b0;
   end

   assign match_a = tick && !block_r && count_value_r == compare_level_a_r;
   assign match_b = tick && !block_r && count_value_r == compare_level_b_r;
   assign at_bottom_evt = tick && fast && at_top;

   always_comb begin
      if (fast)
         ovf_evt = tick && at_top;
      else if (phase)
         ovf_evt = tick && down_r && count_value_r == 8'h01;
      else
         ovf_evt = tick && count_value_r == COUNT_MAX;
   end

   // Match flags land one clock cycle after the match tick
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         match_a_pend_r <= 1'b0;
         match_b_pend_r <= 1'b0;
         ovf_pend_r     <= 1'b0;
      end else if (tick) begin
         match_a_pend_r <= match_a;
         match_b_pend_r <= match_b;
         ovf_pend_r     <= ovf_evt;
      end
   end

   logic tick_d_r;
   always_ff @(posedge aclk) begin
      if (!aresetn)
         tick_d_r <= 1'b0;
      else
         tick_d_r <= tick;
   end

   // Hardware set wins over a simultaneous write-one clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_r <= '0;
      end else begin
         if (ovf_evt)
            flags_r.overflow <= 1'b1;
         else if (flag_write && w_data_r[FLAG_OVF])
            flags_r.overflow <= 1'b0;
         if (tick_d_r && match_a_pend_r)
            flags_r.match_a <= 1'b1;
         else if (flag_write && w_data_r[FLAG_MATA])
            flags_r.match_a <= 1'b0;
         if (tick_d_r && match_b_pend_r)
            flags_r.match_b <= 1'b1;
         else if (flag_write && w_data_r[FLAG_MATB])
            flags_r.match_b <= 1'b0;
      end
   end

   timer_wave_out #(.TOGGLE_IN_PWM(1'b1)) u_wave_a (
      .aclk              (aclk),
      .aresetn           (aresetn),
      .waveform_mode_sel (mode),
      .mode              (ctrl_r.compare_out_mode_a),
      .match             (match_a),
      .at_bottom         (at_bottom_evt),
      .at_top            (at_top),
      .cmp_is_top        (compare_level_a_r == COUNT_MAX),
      .counting_up       (!down_r && !at_top),
      .wave_out          (wave_out_a)
   );

   timer_wave_out #(.TOGGLE_IN_PWM(1'b0)) u_wave_b (
      .aclk              (aclk),
      .aresetn           (aresetn),
      .waveform_mode_sel (mode),
      .mode              (ctrl_r.compare_out_mode_b),
      .match             (match_b),
      .at_bottom         (at_bottom_evt),
      .at_top            (at_top),
      .cmp_is_top        (compare_level_b_r == COUNT_MAX),
      .counting_up       (!down_r && !at_top),
      .wave_out          (wave_out_b)
   );

   // Read side
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire       = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         if (s_axi_araddr[7:2] == ADDR_CTRL[7:2])
            s_axi_rdata <= {20'h00000, ctrl_r};
         else if (s_axi_araddr[7:2] == ADDR_COUNT[7:2])
            s_axi_rdata <= {24'h000000, count_value_r};
         else if (s_axi_araddr[7:2] == ADDR_CMP_A[7:2])
            s_axi_rdata <= {24'h000000, cmp_a_buf_r};
         else if (s_axi_araddr[7:2] == ADDR_CMP_B[7:2])
            s_axi_rdata <= {24'h000000, cmp_b_buf_r};
         else if (s_axi_araddr[7:2] == ADDR_FLAGS[7:2])
            s_axi_rdata <= {29'h00000000, flags_r};
         else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : timer_waveform_modes

// ===== verification/axi_host_model.sv
/* AXI4-Lite master standing in for the processor core.
   Assumes the bench calls one task at a time. */
`timescale 1ns/1ps
module axi_host_model
   import timer_pkg::*;
(
   input  wire logic        aclk,
   output logic [7:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [7:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
      {s_axi_wstrb, s_axi_bready, s_axi_araddr} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
   end

   task automatic write_reg(input logic [7:0] a, input logic [31:0] d,
                            output logic [1:0] r);
      bit aw;
      bit w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hf;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && s_axi_awready === 1'b1) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr  <= ~a;   // Released lines must not keep old value
         end
         if (!w && s_axi_wready === 1'b1) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
            s_axi_wdata  <= ~d;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : write_reg

   task automatic read_reg(input logic [7:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr  <= ~a;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : read_reg
endmodule : axi_host_model

// ===== verification/tb_top.sv
/* Self-checking bench: register access, counting and waveform timing
   against a small model. Assumes the host model and checker exist. */
`timescale 1ns/1ps
module tb_top
   import timer_pkg::*;
;
   logic        aclk, aresetn, wave_out_a, wave_out_b;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          n_errors = 0;
   int          n_tests = 0;
   int unsigned seed = 81;
   int          div[6] = '{0, 1, 8, 64, 256, 1024};

   timer_waveform_modes i_dut (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .wave_out_a, .wave_out_b);
   axi_host_model i_host (.aclk, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd

   task automatic chk(input logic [31:0] got, exp, input string m);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      i_host.write_reg(a, d, r);
      chk(r, RESP_OKAY, "write resp");
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic [1:0] r;
      i_host.read_reg(a, d, r);
      chk(r, RESP_OKAY, "read resp");
   endtask : rd

   function automatic logic [31:0] ctl(int m, int cs, int ca, int cb);
      return {20'h0, ca[1:0], cb[1:0], 1'b0, cs[2:0], 1'b0, m[2:0]};
   endfunction : ctl

   // Expected high time and period in clock cycles
   function automatic void model(input int m, c, l, t, n,
                                 output int hi, per);
      if (m == 1 || m == 5) begin
         per = 2 * t;
         hi = 2 * l;
      end else if (c == 1) begin
         per = 2 * (l + 1);
         hi = l + 1;
      end else begin
         per = t + 1;
         hi = (c == 2) ? l + 1 : t - l;
      end
      per *= n;
      hi *= n;
   endfunction : model

   function automatic logic wv(bit b);
      return b ? wave_out_b : wave_out_a;
   endfunction : wv

   // First partial period is skipped; the output may start either way
   task automatic meas(input bit b, output int hi, output int per);
      int t;
      for (t = 0; t < 5000 && wv(b) !== 1'b0; t++) @(posedge aclk);
      for (t = 0; t < 5000 && wv(b) !== 1'b1; t++) @(posedge aclk);
      for (hi = 0; hi < 5000 && wv(b) === 1'b1; hi++) @(posedge aclk);
      for (per = hi; per < 9000 && wv(b) === 1'b0; per++) @(posedge aclk);
   endtask : meas

   task automatic hold(input bit b, input logic v, input int n);
      int bad;
      bad = 0;
      repeat (n) begin
         @(posedge aclk);
         bad += (wv(b) !== v);
      end
      chk(bad, 0, "level moved");
   endtask : hold

   task automatic run(input int m, ca, cb, la, lb, t, cs, input bit b);
      int hi, per, eh, ep;
      wr(ADDR_CTRL, 0);
      wr(ADDR_COUNT, 0);
      wr(ADDR_CMP_A, la);
      wr(ADDR_CMP_B, lb);
      wr(ADDR_CTRL, ctl(m, cs, ca, cb));
      model(m, b ? cb : ca, b ? lb : la, t, div[cs], eh, ep);
      meas(b, hi, per);
      chk(hi, eh, "high time");
      chk(per, ep, "period");
      $display("test mode %0d done", m);
   endtask : run

   initial begin
      logic [31:0] d;
      logic [7:0]  v;
      logic [1:0]  r;
      aresetn = 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      for (int a = 0; a <= 16; a += 4) begin
         rd(a[7:0], d);
         chk(d, 0, "reset value");
      end
      i_host.read_reg(8'h20, d, r);
      chk(r, RESP_SLVERR, "unmapped read");
      i_host.write_reg(8'h20, 32'h1, r);
      chk(r, RESP_SLVERR, "unmapped write");
      v = rnd();
      wr(ADDR_COUNT, v);
      repeat (20) @(posedge aclk);
      rd(ADDR_COUNT, d);
      chk(d, v, "stopped count");
      $display("test registers done");
      // Modes 0, 4 and 6; set on match first, then clear
      for (int m = 0; m <= 6; m += (m == 0) ? 4 : 2) begin
         wr(ADDR_CTRL, 0);
         wr(ADDR_CMP_A, 8'h10);
         wr(ADDR_COUNT, 8'hf0);
         wr(ADDR_FLAGS, 32'h7);
         rd(ADDR_FLAGS, d);
         chk(d, 0, "flags cleared");
         wr(ADDR_CTRL, ctl(m, 1, 3 - m / 4, 0));
         repeat (48) @(posedge aclk);
         wr(ADDR_CTRL, 0);
         chk(wave_out_a, m == 0, "match output");
         rd(ADDR_COUNT, d);
         chk(d > 32'h10 && d < 32'h60, 1, "wrapped count");
         rd(ADDR_FLAGS, d);
         chk(d[FLAG_OVF], 1, "overflow");
         chk(d[FLAG_MATA], 1, "match a");
      end
      $display("test normal done");
      repeat (2) begin
         v = rnd() & 8'h0f;
         run(2, 1, 0, v, 0, v, 1, 0);
      end
      rd(ADDR_COUNT, d);
      chk(d <= v, 1, "count above top");
      rd(ADDR_FLAGS, d);
      chk(d[FLAG_MATA], 1, "match a");
      for (int cs = 2; cs <= 5; cs++) run(2, 1, 0, 0, 0, 0, cs, 0);
      run(3, 2, 0, 8'h40, 0, 255, 1, 0);
      run(3, 3, 0, 8'h40, 0, 255, 1, 0);
      run(7, 1, 1, 4, 0, 4, 1, 0);
      hold(1, 1'b0, 40);
      run(1, 2, 0, 8'h40, 0, 255, 1, 0);
      run(5, 0, 2, 8'h30, 8'h10, 8'h30, 1, 1);
      run(3, 2, 0, 0, 0, 255, 1, 0);
      wr(ADDR_CMP_A, 8'hff);
      repeat (300) @(posedge aclk);
      hold(0, 1'b1, 256);
      $display("test extremes done");
      finish_test();
   end

   // Longest run is under 12000 cycles
   initial begin
      repeat (60000) @(posedge aclk);
      n_errors++;
      $display("wrong value at %0t: run did not finish", $time);
      finish_test();
   end
endmodule : tb_top

// ===== verification/timer_waveform_modes_chk.sv
/* Register port checks for the waveform timer.
   Bound to timer_waveform_modes; sees only its bus ports. */
`timescale 1ns/1ps
module timer_waveform_modes_chk
   import timer_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_bresp_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
         && $stable(s_axi_bresp)) else $error("write answer not held");
   a_rdata_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
         && $stable(s_axi_rdata)) else $error("read answer not held");
   a_rvalid_drop:
      assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
         else $error("read answer repeated");
   a_write_block:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
         else $error("write taken during answer");
   a_read_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
         else $error("read answer late");
   a_write_answer:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
         && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write late");
   a_unmapped_read:
      assert property (s_axi_arvalid && s_axi_arready
         && s_axi_araddr[7:2] > ADDR_FLAGS[7:2] |=> s_axi_rresp
         == RESP_SLVERR && s_axi_rdata == 32'h0)
         else $error("unmapped read accepted");
   a_mapped_read:
      assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr
         <= ADDR_FLAGS && s_axi_araddr[1:0] == 2'b00 |=> s_axi_rresp
         == RESP_OKAY) else $error("mapped read refused");
endmodule : timer_waveform_modes_chk

bind timer_waveform_modes timer_waveform_modes_chk i_chk (.aclk,
   .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
